// ### design/four_level_irq_ctl.sv
// Four level interrupt controller with vectoring, preemption and wake logic.
// What this block does
// - Thirteen sources arbitrated over four levels.
// - Per-source enables plus global gate bit.
// - Two bits per source pick its level.
// - Only strictly higher levels preempt service.
// - Top level service is never preempted.
// - Higher level wins among simultaneous requests.
// - Equal levels resolved by fixed polling order.
// - Polling order fixed, external 0 first.
// - Each source has its fixed vector address.
// - Only listed sources may wake power-down.
// - Enable and priority bits at fixed positions.
// - Sense select picks low level or edge.
// - Edge mode flags high then low samples.
// - Edge flag clears when core vectors.
// - Level request held; reasserts after return.
// - Level flag follows pin, no clearing.
// - Enabled external pin wakes idle or power-down.
`timescale 1ns/100ps
module four_level_irq_ctl (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  irq_enable_reg_a,
    input  wire logic [7:0]  irq_enable_reg_b,
    input  wire logic [7:0]  prio_low_reg_a,
    input  wire logic [7:0]  prio_high_reg_a,
    input  wire logic [7:0]  prio_low_reg_b,
    input  wire logic [7:0]  prio_high_reg_b,
    input  wire logic        cfg_write,
    input  wire logic        ext0_sense_sel,
    input  wire logic        ext1_sense_sel,
    input  wire logic        ext0_irq_pin_n,
    input  wire logic        ext1_irq_pin_n,
    input  wire logic        tmr0_overflow_flag,
    input  wire logic        tmr1_overflow_flag,
    input  wire logic        serial_tx_flag,
    input  wire logic        serial_rx_flag,
    input  wire logic        brownout_flag,
    input  wire logic        twowire_attention_flag,
    input  wire logic        keypad_flag,
    input  wire logic        cmp1_flag,
    input  wire logic        cmp2_flag,
    input  wire logic        wdog_overflow_flag,
    input  wire logic        converter_done_flag,
    input  wire logic        bus_timeout_flag,
    input  wire logic        core_ack,
    input  wire logic        core_return,
    input  wire logic        sleeping,
    output logic             irq_request,
    output logic [15:0]      irq_vector,
    output logic             ext0_req_flag,
    output logic             ext1_req_flag,
    output logic             wake_request,
    output logic             in_service,
    output logic [1:0]       active_level
);
    localparam int N = irq_ctl_pkg::NUM_SRC;
    // Four nested routines at most, one per level.
    localparam logic [2:0] STACK_MAX  = 3'h4;
    localparam logic [2:0] STACK_NONE = 3'h0;

    // Registered controller state; depth-four stack holds levels in service.
    typedef struct packed {
        logic [7:0]   en_a;
        logic [7:0]   en_b;
        logic [7:0]   pl_a;
        logic [7:0]   ph_a;
        logic [7:0]   pl_b;
        logic [7:0]   ph_b;
        logic         sel0;
        logic         sel1;
        logic [2:0]   mc_cnt;
        logic [2:0]   depth;
        logic [7:0]   lvl_stack;
        logic         req;
        logic [15:0]  vec;
        logic [3:0]   idx;
        logic [1:0]   lvl;        // Level of the offered source.
        logic         wake;
        logic         busy;       // Stack not empty.
    } ctl_state_t;

    ctl_state_t state_reg;
    ctl_state_t state_next;

    logic         mc_tick;
    logic         ack0;
    logic         ack1;
    logic         ext0_flag;
    logic         ext1_flag;
    logic         low0;
    logic         low1;
    logic [N-1:0] raw;
    logic [N-1:0] en;
    logic [N-1:0] pend;
    logic [2*N-1:0] lvl;
    logic         found;
    logic [3:0]   win_idx;
    logic [1:0]   win_lvl;
    logic [1:0]   cur_lvl;
    logic         may_preempt;

    // One tick per machine cycle paces the pin samplers.
    assign mc_tick = (state_reg.mc_cnt == 3'(irq_ctl_pkg::MC_CLKS - 1));
    // A grant to an external source clears its edge flag.
    assign ack0 = core_ack && state_reg.req && state_reg.idx == irq_ctl_pkg::SRC_EXT0;
    assign ack1 = core_ack && state_reg.req && state_reg.idx == irq_ctl_pkg::SRC_EXT1;

    // Samplers for the two external pins.
    ext_pin_sense u_ext0 (
        .clock      (clock),
        .reset      (reset),
        .mc_tick    (mc_tick),
        .pin_n      (ext0_irq_pin_n),
        .edge_mode  (state_reg.sel0),
        .vector_ack (ack0),
        .req_flag   (ext0_flag),
        .low_seen   (low0)
    );

    ext_pin_sense u_ext1 (
        .clock      (clock),
        .reset      (reset),
        .mc_tick    (mc_tick),
        .pin_n      (ext1_irq_pin_n),
        .edge_mode  (state_reg.sel1),
        .vector_ack (ack1),
        .req_flag   (ext1_flag),
        .low_seen   (low1)
    );

    // Gather flags, enables and level bits in polling order.
    always_comb begin
        raw = {bus_timeout_flag, serial_tx_flag | serial_rx_flag, cmp2_flag,
               tmr1_overflow_flag, cmp1_flag, keypad_flag, ext1_flag,
               converter_done_flag, twowire_attention_flag, tmr0_overflow_flag,
               wdog_overflow_flag, brownout_flag, ext0_flag};
        en = {state_reg.en_b[irq_ctl_pkg::BIT_TMOT], state_reg.en_a[irq_ctl_pkg::BIT_SER],
              state_reg.en_b[irq_ctl_pkg::BIT_CMP2], state_reg.en_a[irq_ctl_pkg::BIT_TMR1],
              state_reg.en_b[irq_ctl_pkg::BIT_CMP1], state_reg.en_b[irq_ctl_pkg::BIT_KEYP],
              state_reg.en_a[irq_ctl_pkg::BIT_EXT1], state_reg.en_b[irq_ctl_pkg::BIT_CONV],
              state_reg.en_b[irq_ctl_pkg::BIT_TWB], state_reg.en_a[irq_ctl_pkg::BIT_TMR0],
              state_reg.en_a[irq_ctl_pkg::BIT_WDOG], state_reg.en_a[irq_ctl_pkg::BIT_BOD],
              state_reg.en_a[irq_ctl_pkg::BIT_EXT0]};
        lvl = {state_reg.ph_b[irq_ctl_pkg::BIT_TMOT], state_reg.pl_b[irq_ctl_pkg::BIT_TMOT],
               state_reg.ph_a[irq_ctl_pkg::BIT_SER], state_reg.pl_a[irq_ctl_pkg::BIT_SER],
               state_reg.ph_b[irq_ctl_pkg::BIT_CMP2], state_reg.pl_b[irq_ctl_pkg::BIT_CMP2],
               state_reg.ph_a[irq_ctl_pkg::BIT_TMR1], state_reg.pl_a[irq_ctl_pkg::BIT_TMR1],
               state_reg.ph_b[irq_ctl_pkg::BIT_CMP1], state_reg.pl_b[irq_ctl_pkg::BIT_CMP1],
               state_reg.ph_b[irq_ctl_pkg::BIT_KEYP], state_reg.pl_b[irq_ctl_pkg::BIT_KEYP],
               state_reg.ph_a[irq_ctl_pkg::BIT_EXT1], state_reg.pl_a[irq_ctl_pkg::BIT_EXT1],
               state_reg.ph_b[irq_ctl_pkg::BIT_CONV], state_reg.pl_b[irq_ctl_pkg::BIT_CONV],
               state_reg.ph_b[irq_ctl_pkg::BIT_TWB], state_reg.pl_b[irq_ctl_pkg::BIT_TWB],
               state_reg.ph_a[irq_ctl_pkg::BIT_TMR0], state_reg.pl_a[irq_ctl_pkg::BIT_TMR0],
               state_reg.ph_a[irq_ctl_pkg::BIT_WDOG], state_reg.pl_a[irq_ctl_pkg::BIT_WDOG],
               state_reg.ph_a[irq_ctl_pkg::BIT_BOD], state_reg.pl_a[irq_ctl_pkg::BIT_BOD],
               state_reg.ph_a[irq_ctl_pkg::BIT_EXT0],
               state_reg.pl_a[irq_ctl_pkg::BIT_EXT0]};
        // The global gate masks every source at once.
        pend = raw & en & {N{state_reg.en_a[irq_ctl_pkg::BIT_GATE]}};
    end

    // Fixed ranking among the enabled, gated sources.
    prio_pick #(
        .N (N)
    ) u_pick (
        .pend      (pend),
        .level     (lvl),
        .found     (found),
        .index     (win_idx),
        .win_level (win_lvl)
    );

    // Level of the routine in service sits at the top of the stack.
    assign cur_lvl = state_reg.lvl_stack[1:0];
    // Equal levels wait, so a routine never interrupts itself.
    assign may_preempt = (state_reg.depth == STACK_NONE) ||
                         (cur_lvl != irq_ctl_pkg::PRIO_TOP && win_lvl > cur_lvl);

    // Next-state: config capture, machine cycle divider, stack, request.
    always_comb begin
        state_next = state_reg;
        if (cfg_write) begin
            state_next.en_a = irq_enable_reg_a;
            state_next.en_b = irq_enable_reg_b;
            state_next.pl_a = prio_low_reg_a;
            state_next.ph_a = prio_high_reg_a;
            state_next.pl_b = prio_low_reg_b;
            state_next.ph_b = prio_high_reg_b;
            state_next.sel0 = ext0_sense_sel;
            state_next.sel1 = ext1_sense_sel;
        end
        state_next.mc_cnt = mc_tick ? 3'h0 : state_reg.mc_cnt + 3'h1;
        if (core_ack && state_reg.req) begin
            // Push the level offered with the vector. A source arriving
            // in the grant cycle must not change the active level.
            state_next.lvl_stack = {state_reg.lvl_stack[5:0], state_reg.lvl};
            state_next.depth     = state_reg.depth + 3'h1;
            state_next.req       = 1'b0;
        end else if (core_return && state_reg.depth != STACK_NONE) begin
            // Pop back to the interrupted level.
            state_next.lvl_stack = {2'h0, state_reg.lvl_stack[7:2]};
            state_next.depth     = state_reg.depth - 3'h1;
            state_next.req       = 1'b0;
        end else begin
            // The offer is recomputed in every cycle without a grant or return,
            // so vector, index and level always name one and the same source.
            state_next.req = found && may_preempt && state_reg.depth != STACK_MAX;
            state_next.idx = win_idx;
            state_next.lvl = win_lvl;
            state_next.vec = irq_ctl_pkg::VECTORS[win_idx*irq_ctl_pkg::VEC_W +: 16];
        end
        // A registered busy flag keeps the service output on a flip-flop.
        state_next.busy = (state_next.depth != STACK_NONE);
        // Wake: enabled wake-capable source, or enabled low pin, while asleep.
        state_next.wake = sleeping &&
                          (|(pend & irq_ctl_pkg::WAKE_OK) ||
                           (low0 && en[irq_ctl_pkg::SRC_EXT0]) ||
                           (low1 && en[irq_ctl_pkg::SRC_EXT1]));
    end

    // Synchronous reset clears enables, levels and the stack.
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state flip-flops or the pin flags.
    assign irq_request   = state_reg.req;
    assign irq_vector    = state_reg.vec;
    assign ext0_req_flag = ext0_flag;
    assign ext1_req_flag = ext1_flag;
    assign wake_request  = state_reg.wake;
    assign in_service    = state_reg.busy;
    assign active_level  = cur_lvl;

    // Checks of the main relations.
    // Nothing interrupts top level service.
    a_top_no_preempt: assert property (@(posedge clock) disable iff (reset)
        (in_service && active_level == 2'h3 && !core_return) |=> !irq_request)
        else $error("Top level service was preempted.");
    // A closed gate masks every source.
    a_gate_blocks: assert property (@(posedge clock) disable iff (reset)
        !state_reg.en_a[irq_ctl_pkg::BIT_GATE] && !core_ack && !core_return
        |=> !irq_request)
        else $error("Request raised with gate closed.");
    // Equal or lower levels must wait.
    a_higher_only: assert property (@(posedge clock) disable iff (reset)
        (in_service && win_lvl <= active_level && !core_ack && !core_return)
        |=> !irq_request)
        else $error("Equal or lower level preempted.");
    // A grant enters service and drops the offer.
    a_ack_pushes: assert property (@(posedge clock) disable iff (reset)
        (core_ack && irq_request) |=> in_service && !irq_request)
        else $error("Grant did not enter service.");
    // The last return leaves service.
    a_return_pops: assert property (@(posedge clock) disable iff (reset)
        (core_return && !core_ack && state_reg.depth == 3'h1) |=> !in_service)
        else $error("Return did not restore idle level.");
    // Wake is only raised while asleep.
    a_wake_sleep: assert property (@(posedge clock) disable iff (reset)
        wake_request |-> $past(sleeping))
        else $error("Wake raised while awake.");
    // Vectoring clears the edge flag unless a new edge lands.
    a_edge_clear: assert property (@(posedge clock) disable iff (reset)
        (ack0 && state_reg.sel0 && !mc_tick) |=> !ext0_req_flag)
        else $error("Edge flag not cleared on vector.");
    // The first source offers its own vector.
    a_vec_ext0: assert property (@(posedge clock) disable iff (reset)
        (irq_request && state_reg.idx == 4'h0) |-> irq_vector == 16'h0003)
        else $error("Wrong vector for external 0.");

    // Grants stop at the stack limit, so no level is lost.
    a_stack_bound: assert property (@(posedge clock) disable iff (reset)
        state_reg.depth <= STACK_MAX)
        else $error("Level stack overflowed.");
    // A grant makes the offered level the active one.
    a_grant_level: assert property (@(posedge clock) disable iff (reset)
        (core_ack && irq_request) |=> active_level == $past(state_reg.lvl))
        else $error("Granted level not made active.");
    // Sources that may not wake leave the wake output low.
    a_wake_capable: assert property (@(posedge clock) disable iff (reset)
        !(|(pend & irq_ctl_pkg::WAKE_OK)) && !low0 && !low1 |=> !wake_request)
        else $error("Wake raised by a source that may not wake.");
    // A return restores the level that was interrupted.
    a_return_level: assert property (@(posedge clock) disable iff (reset)
        (core_return && !core_ack && state_reg.depth == 3'h2)
        |=> active_level == $past(state_reg.lvl_stack[3:2]))
        else $error("Return did not restore the outer level.");

    // Covers for the main scenarios.
    c_nested: cover property (@(posedge clock) state_reg.depth == 3'h2);
    c_wake: cover property (@(posedge clock) wake_request);
    c_edge: cover property (@(posedge clock) ext1_req_flag && state_reg.sel1);
    c_top_level: cover property (@(posedge clock) active_level == irq_ctl_pkg::PRIO_TOP);
    c_reentry: cover property (@(posedge clock) core_return ##1 irq_request);
endmodule : four_level_irq_ctl

// ### design/irq_ctl_pkg.sv
// Constants shared by the four level interrupt controller files.
package irq_ctl_pkg;
    localparam int NUM_SRC   = 13;
    localparam int PRIO_W    = 2;
    localparam int IDX_W     = 4;
    localparam int VEC_W     = 16;
    localparam int MC_CLKS   = 6;       // CPU clocks per machine cycle.
    localparam int MC_W      = 3;

    // Source index, listed in fixed tie-break order, first wins.
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_BOD  = 4'h1;
    localparam logic [3:0] SRC_WDOG = 4'h2;
    localparam logic [3:0] SRC_TMR0 = 4'h3;
    localparam logic [3:0] SRC_TWB  = 4'h4;
    localparam logic [3:0] SRC_CONV = 4'h5;
    localparam logic [3:0] SRC_EXT1 = 4'h6;
    localparam logic [3:0] SRC_KEYP = 4'h7;
    localparam logic [3:0] SRC_CMP1 = 4'h8;
    localparam logic [3:0] SRC_TMR1 = 4'h9;
    localparam logic [3:0] SRC_CMP2 = 4'hA;
    localparam logic [3:0] SRC_SER  = 4'hB;
    localparam logic [3:0] SRC_TMOT = 4'hC;

    // Bit positions of each source in the A and B enable and priority registers.
    localparam int BIT_EXT0 = 0;
    localparam int BIT_TMR0 = 1;
    localparam int BIT_EXT1 = 2;
    localparam int BIT_TMR1 = 3;
    localparam int BIT_SER  = 4;
    localparam int BIT_BOD  = 5;
    localparam int BIT_WDOG = 6;
    localparam int BIT_GATE = 7;
    localparam int BIT_TWB  = 0;
    localparam int BIT_KEYP = 1;
    localparam int BIT_CMP2 = 2;
    localparam int BIT_CONV = 4;
    localparam int BIT_CMP1 = 5;
    localparam int BIT_TMOT = 7;

    // Service vectors, indexed by tie-break position.
    localparam logic [NUM_SRC*VEC_W-1:0] VECTORS = {
        16'h0073, 16'h0023, 16'h0043, 16'h001B, 16'h0063, 16'h003B, 16'h0013,
        16'h005B, 16'h0033, 16'h000B, 16'h0053, 16'h002B, 16'h0003};

    // Wake capability, indexed by tie-break position.
    localparam logic [NUM_SRC-1:0] WAKE_OK = 13'b0_0101_1110_0111;

    localparam logic [PRIO_W-1:0] PRIO_TOP = 2'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
endpackage : irq_ctl_pkg

// ### design/ext_pin_sense.sv
// One external interrupt pin: synchroniser, machine cycle sampler and flag.
`timescale 1ns/100ps
module ext_pin_sense (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic mc_tick,
    input  wire logic pin_n,
    input  wire logic edge_mode,
    input  wire logic vector_ack,
    output logic      req_flag,
    output logic      low_seen
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sample;
        logic flag;
    } pin_state_t;

    pin_state_t state_reg;
    pin_state_t state_next;

    // Sample once per machine cycle; edge flag is set high then low, cleared on vector.
    always_comb begin
        state_next       = state_reg;
        state_next.sync1 = pin_n;
        state_next.sync2 = state_reg.sync1;
        if (mc_tick) begin
            state_next.sample = state_reg.sync2;
        end
        if (edge_mode) begin
            if (vector_ack) begin
                state_next.flag = 1'b0;
            end
            if (mc_tick && state_reg.sample && !state_reg.sync2) begin
                state_next.flag = 1'b1;
            end
        end else begin
            state_next.flag = !state_reg.sample;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= '{sync1: 1'b1, sync2: 1'b1, sample: 1'b1, flag: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign req_flag = state_reg.flag;
    assign low_seen = !state_reg.sample;
endmodule : ext_pin_sense

// ### design/prio_pick.sv
// Picks the highest level pending source, first in tie order among equals.
`timescale 1ns/100ps
module prio_pick #(
    parameter int N = irq_ctl_pkg::NUM_SRC
) (
    input  wire logic [N-1:0]   pend,
    input  wire logic [2*N-1:0] level,
    output logic                found,
    output logic [3:0]          index,
    output logic [1:0]          win_level
);
    // Scan from last to first so the earliest equal-level entry wins.
    always_comb begin
        found     = 1'b0;
        index     = 4'h0;
        win_level = 2'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i] && (!found || level[2*i +: 2] >= win_level)) begin
                found     = 1'b1;
                index     = 4'(i);
                win_level = level[2*i +: 2];
            end
        end
    end
endmodule : prio_pick

// ### verification/core_model.sv
// Behavioural CPU core that takes offered vectors after a set delay.
`timescale 1ns/100ps
module core_model (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        irq_request,
    input  wire logic [15:0] irq_vector,
    input  wire logic        ack_en,
    input  wire logic [3:0]  ack_delay,
    output logic             core_ack,
    output logic [15:0]      taken_vector,
    output logic [7:0]       take_count
);
    int wait_cnt;

    // Start idle so the controller never sees an unknown acknowledge.
    initial begin
        core_ack = 1'b0;
        taken_vector = 16'h0000;
        take_count = 8'h00;
    end

    // Waits on a standing offer, then holds the acknowledge for one sampled edge.
    always @(posedge clock) begin
        if (core_ack && irq_request) begin
            taken_vector <= irq_vector;
            take_count <= take_count + 8'h01;
        end
        if (reset || core_ack || !irq_request || !ack_en) begin
            wait_cnt <= 0;
            core_ack <= #1 1'b0;
        end else if (wait_cnt >= int'(ack_delay)) begin
            core_ack <= #1 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule : core_model

// ### verification/tb_top.sv
// Self-checking bench for the four level interrupt controller.
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  en_a, en_b, pl_a, pl_b, ph_a, ph_b;
    logic        cfg_write, s0, s1, pin0_n, pin1_n, core_return, sleeping, ack_en;
    logic [12:0] flags;
    logic [3:0]  ack_delay;
    logic        irq_request, ext0_req_flag, ext1_req_flag, wake_request, in_service;
    logic        core_ack;
    logic [15:0] irq_vector, taken_vector;
    logic [1:0]  active_level;
    logic [7:0]  take_count;
    int          mismatches = 0;
    int          compares = 0;
    int          i;
    logic [15:0] en_bit [13] = '{16'h0001, 16'h0020, 16'h0040, 16'h0002, 16'h0100, 16'h1000,
        16'h0004, 16'h0200, 16'h2000, 16'h0008, 16'h0400, 16'h0010, 16'h8000};
    logic [15:0] vec [13] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
        16'h0013, 16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h0023, 16'h0073};
    logic [12:0] wake_ok = 13'h05E7;

    four_level_irq_ctl dut (.clock(clock), .reset(reset), .irq_enable_reg_a(en_a),
        .irq_enable_reg_b(en_b), .prio_low_reg_a(pl_a), .prio_high_reg_a(ph_a),
        .prio_low_reg_b(pl_b), .prio_high_reg_b(ph_b), .cfg_write(cfg_write),
        .ext0_sense_sel(s0), .ext1_sense_sel(s1), .ext0_irq_pin_n(pin0_n),
        .ext1_irq_pin_n(pin1_n), .tmr0_overflow_flag(flags[3]), .tmr1_overflow_flag(flags[9]),
        .serial_tx_flag(flags[11]), .serial_rx_flag(flags[11]), .brownout_flag(flags[1]),
        .twowire_attention_flag(flags[4]), .keypad_flag(flags[7]), .cmp1_flag(flags[8]),
        .cmp2_flag(flags[10]), .wdog_overflow_flag(flags[2]), .converter_done_flag(flags[5]),
        .bus_timeout_flag(flags[12]), .core_ack(core_ack), .core_return(core_return),
        .sleeping(sleeping), .irq_request(irq_request), .irq_vector(irq_vector),
        .ext0_req_flag(ext0_req_flag), .ext1_req_flag(ext1_req_flag),
        .wake_request(wake_request), .in_service(in_service), .active_level(active_level));

    core_model core (.clock(clock), .reset(reset), .irq_request(irq_request),
        .irq_vector(irq_vector), .ack_en(ack_en), .ack_delay(ack_delay), .core_ack(core_ack),
        .taken_vector(taken_vector), .take_count(take_count));

    // Free running 10 MHz clock.
    always #50 clock = ~clock;

    // Prints the verdict and ends the run.
    task automatic results;
        if (mismatches == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    // Lets n edges pass, then settles just after the last one.
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    // Loads all register images and sense selects with a one-cycle capture pulse.
    task automatic cfg(input logic [15:0] en, input logic [15:0] plo, input logic [15:0] phi,
                       input logic m0, input logic m1);
        {en_b, en_a} = en;
        {pl_b, pl_a} = plo;
        {ph_b, ph_a} = phi;
        s0 = m0;
        s1 = m1;
        cfg_write = 1'b1;
        step(1);
        cfg_write = 1'b0;
    endtask : cfg

    // Raises or drops a source given by its tie order position; pins are active low.
    task automatic src(input int k, input logic v);
        if (k == 0) pin0_n = ~v;
        else if (k == 6) pin1_n = ~v;
        else flags[k] = v;
    endtask : src

    // Waits a bounded time for an offer.
    task automatic wait_req;
        int n;
        for (n = 0; n < 30 && irq_request !== 1'b1; n++) step(1);
        if (irq_request !== 1'b1) begin
            mismatches++;
            results();
        end
    endtask : wait_req

    // Lets the core model take the standing offer.
    task automatic take;
        logic [7:0] c0;
        int n;
        c0 = take_count;
        ack_en = 1'b1;
        for (n = 0; n < 40 && take_count === c0; n++) step(1);
        ack_en = 1'b0;
        if (take_count === c0) begin
            mismatches++;
            results();
        end
    endtask : take

    // Signals the end of a service routine.
    task automatic ret;
        core_return = 1'b1;
        step(1);
        core_return = 1'b0;
    endtask : ret

    // Checks that no offer appears for n cycles.
    task automatic quiet(input int n);
        repeat (n) begin
            step(1);
            `CHECK("irq_request", 1'b0, irq_request)
        end
    endtask : quiet

    // Bounds the whole run.
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        results();
    end

    // Main sequence.
    initial begin
        {en_a, en_b, pl_a, pl_b, ph_a, ph_b} = 48'h0;
        {cfg_write, s0, s1, core_return, sleeping, ack_en} = 6'h00;
        {pin0_n, pin1_n} = 2'h3;
        flags = 13'h0000;
        ack_delay = 4'h0;
        repeat (20) @(posedge clock);
        #1 reset = 1'b0;
        `CHECK("irq_request", 1'b0, irq_request)
        `CHECK("in_service", 1'b0, in_service)
        `CHECK("ext_flags", 2'h0, {ext0_req_flag, ext1_req_flag})
        cfg(16'hB77F, 16'h0000, 16'h0000, 1'b0, 1'b0);
        flags[3] = 1'b1;
        quiet(15);
        flags[3] = 1'b0;
        sleeping = 1'b1;
        for (i = 0; i < 13; i++) begin
            ack_delay = (i % 2 != 0) ? 4'h5 : 4'h0;
            cfg(en_bit[i] | 16'h0080, 16'h0000, 16'h0000, 1'b0, 1'b0);
            src(i, 1'b1);
            wait_req();
            step(1);
            `CHECK("irq_vector", vec[i], irq_vector)
            `CHECK("wake_request", wake_ok[i], wake_request)
            take();
            `CHECK("taken_vector", vec[i], taken_vector)
            src(i, 1'b0);
            step(16);
            ret();
            `CHECK("in_service", 1'b0, in_service)
        end
        sleeping = 1'b0;
        cfg(16'h00AA, 16'h0000, 16'h0000, 1'b0, 1'b0);
        flags[1] = 1'b1;
        flags[9] = 1'b1;
        wait_req();
        `CHECK("irq_vector", 16'h002B, irq_vector)
        cfg(16'h00AA, 16'h000A, 16'h000A, 1'b0, 1'b0);
        step(2);
        `CHECK("irq_vector", 16'h001B, irq_vector)
        take();
        `CHECK("active_level", 2'h3, active_level)
        flags[3] = 1'b1;
        quiet(12);
        flags[9] = 1'b0;
        ret();
        wait_req();
        `CHECK("irq_vector", 16'h000B, irq_vector)
        take();
        flags[3] = 1'b0;
        ret();
        wait_req();
        `CHECK("irq_vector", 16'h002B, irq_vector)
        take();
        flags[1] = 1'b0;
        ret();
        cfg(16'h1482, 16'h0402, 16'h1000, 1'b0, 1'b0);
        flags[3] = 1'b1;
        wait_req();
        take();
        `CHECK("active_level", 2'h1, active_level)
        flags[10] = 1'b1;
        quiet(12);
        flags[5] = 1'b1;
        wait_req();
        `CHECK("irq_vector", 16'h005B, irq_vector)
        take();
        `CHECK("active_level", 2'h2, active_level)
        flags[5] = 1'b0;
        ret();
        `CHECK("active_level", 2'h1, active_level)
        flags[3] = 1'b0;
        ret();
        wait_req();
        `CHECK("irq_vector", 16'h0043, irq_vector)
        take();
        flags[10] = 1'b0;
        ret();
        cfg(16'h0085, 16'h0000, 16'h0000, 1'b1, 1'b1);
        {pin0_n, pin1_n} = 2'h0;
        for (i = 0; i < 14 && ext1_req_flag !== 1'b1; i++) step(1);
        `CHECK("ext1_req_flag", 1'b1, ext1_req_flag)
        wait_req();
        `CHECK("irq_vector", 16'h0003, irq_vector)
        take();
        `CHECK("ext0_req_flag", 1'b0, ext0_req_flag)
        ret();
        wait_req();
        `CHECK("irq_vector", 16'h0013, irq_vector)
        take();
        step(2);
        `CHECK("ext1_req_flag", 1'b0, ext1_req_flag)
        ret();
        quiet(12);
        {pin0_n, pin1_n} = 2'h3;
        cfg(16'h0081, 16'h0000, 16'h0000, 1'b0, 1'b0);
        pin0_n = 1'b0;
        wait_req();
        `CHECK("ext0_req_flag", 1'b1, ext0_req_flag)
        take();
        step(2);
        ret();
        wait_req();
        `CHECK("irq_vector", 16'h0003, irq_vector)
        take();
        pin0_n = 1'b1;
        step(12);
        `CHECK("ext0_req_flag", 1'b0, ext0_req_flag)
        pin0_n = 1'b0;
        reset = 1'b1;
        step(2);
        reset = 1'b0;
        `CHECK("in_service", 1'b0, in_service)
        quiet(12);
        ret();
        `CHECK("in_service", 1'b0, in_service)
        results();
    end
endmodule : tb_top
